// File: bench/cpu_core_model.sv
// cpu core side: acknowledges delivered interrupts after a chosen delay
`timescale 1ns/10ps
module cpu_core_model
    import event_combiner_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_CPU_INT-1:0] cpu_int,
    input wire logic [3:0] ack_delay,
    input wire logic hold,
    output logic [NUM_CPU_INT-1:0] int_ack
);
    logic [NUM_CPU_INT-1:0][3:0] wait_cnt;
    // ==========================================
    // ack engine
    // hold stalls servicing so a second event finds the channel still pending
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= '0;
            int_ack <= '0;
        end else begin
            for (int i = 0; i < NUM_CPU_INT; i++) begin
                int_ack[i] <= !hold && !cpu_int[i] && wait_cnt[i] == 4'h1;
                if (cpu_int[i]) begin
                    wait_cnt[i] <= ack_delay;
                end else if (!hold && wait_cnt[i] != 4'h0) begin
                    wait_cnt[i] <= wait_cnt[i] - 4'h1;
                end
            end
        end
    end
endmodule

// File: bench/event_combiner_tb.sv
// self-checking bench for the event combiner against a cpu core model
`timescale 1ns/10ps
module event_combiner_tb import event_combiner_pkg::*; ();
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [NUM_EVENTS-1:0] ev_in, ev_set, ev_clr, ev_mask, exc_en, flags, mflags;
    logic [NUM_CPU_INT-1:0][EVT_SEL_W-1:0] sel;
    logic [NUM_CPU_INT-1:0] ack, cpu_int, pend;
    logic [HIGHEST_W-1:0] highest;
    logic exc, nmi, hold;
    logic [2:0] emu;
    logic [3:0] ack_delay;
    int fail_count = 0;
    int n_tests = 0;
    int e, ch;
    always #10 clk = ~clk;
    event_combiner u_event_combiner(.CLK(clk), .RST_B(rst_b), .EVENT_IN(ev_in),
        .EVENT_SET(ev_set), .EVENT_CLEAR(ev_clr), .EVENT_MASK(ev_mask),
        .EXCEPTION_ENABLE(exc_en), .INT_SEL(sel), .INT_ACK(ack), .EVENT_FLAGS(flags),
        .MASKED_FLAGS(mflags), .CPU_INT(cpu_int), .CPU_INT_PENDING(pend),
        .HIGHEST_INT(highest), .CPU_EXCEPTION(exc), .EMU_INT(emu), .CPU_NMI(nmi));
    cpu_core_model u_cpu_core_model(.clk(clk), .rst_b(rst_b), .cpu_int(cpu_int),
        .ack_delay(ack_delay), .hold(hold), .int_ack(ack));
    // ==========================================
    // helpers
    // beyond the fixed table an event is live unless it is reserved or internal (0-3 and 96)
    function automatic logic real_evt(input int n);
        return (n >= 4 && n <= 9) || (n >= 11 && n <= 14) || (n >= 64 && n <= 78)
            || (n >= 80 && n <= 85)
            || (((n >= 25 && n <= 63) || n >= 89) && n != 96 && !RESERVED_MASK[n]);
    endfunction
    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_vec(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t value got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic pulse_in(input int n);
        @(posedge clk);
        ev_in[n] <= 1'b1;
        @(posedge clk);
        ev_in[n] <= 1'b0;
    endtask
    // clearing every flag keeps later channel edges clean
    task automatic clear_all();
        @(posedge clk);
        ev_clr <= '1;
        @(posedge clk);
        ev_clr <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic run_one(input int n, input int c);
        @(posedge clk);
        sel[c] <= 7'(n);
        ack_delay <= 4'($urandom_range(6, 1));
        repeat (2) @(posedge clk);
        pulse_in(n);
        @(negedge clk);
        check_bit(flags[n], real_evt(n));
        check_bit(cpu_int[c], real_evt(n));
        check_bit(pend[c], real_evt(n));
        @(negedge clk);
        check_bit(cpu_int[c], 1'b0);
        check_vec(128'(highest), real_evt(n) ? 128'(c) : 128'(4'hF));
        repeat (4) @(posedge clk);
        sel[c] <= 7'h0A;
        clear_all();
        @(negedge clk);
        check_bit(pend[c], 1'b0);
    endtask
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {ev_in, ev_set, ev_clr, exc_en} = '0;
        ev_mask = '1;
        sel = {NUM_CPU_INT{7'h0A}};
        ack_delay = 4'h1;
        hold = 1'b0;
        void'($urandom(32'h30fa));
        repeat (11) @(posedge clk);
        @(negedge clk);
        check_vec(128'(highest), 128'(4'hF));
        @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 30; i++) begin
            e = i < 6 ? (i == 0 ? 84 : i == 1 ? 10 : i == 2 ? 127 : i * 16) : 0;
            ch = i == 0 ? 3 : 32'($urandom_range(11));
            while (e < 4 || e == 96) e = 32'($urandom_range(127));
            run_one(e, ch);
        end
        // second event while the core stalls must be dropped
        @(posedge clk);
        hold <= 1'b1;
        sel[5] <= 7'h08;
        pulse_in(8);
        @(negedge clk);
        check_bit(cpu_int[5], 1'b1);
        check_bit(flags[96], 1'b0);
        @(posedge clk);
        ev_clr[8] <= 1'b1;
        @(posedge clk);
        ev_clr[8] <= 1'b0;
        pulse_in(8);
        repeat (4) begin
            @(negedge clk);
            check_bit(cpu_int[5], 1'b0);
        end
        check_bit(flags[96], 1'b1);
        // mid-run reset drops flags, pending state and the priority index
        @(posedge clk);
        hold <= 1'b0;
        sel[5] <= 7'h0A;
        rst_b <= 1'b0;
        @(negedge clk);
        check_vec(flags, '0);
        check_vec(128'(pend), '0);
        check_vec(128'(highest), 128'(4'hF));
        @(posedge clk);
        rst_b <= 1'b1;
        // set beats clear, then mask, exception and combined group event
        @(posedge clk);
        {ev_set[64], ev_clr[64], ev_mask[64], exc_en[64]} <= 4'hD;
        @(posedge clk);
        {ev_set[64], ev_clr[64]} <= 2'h0;
        @(negedge clk);
        check_bit(flags[64], 1'b1);
        @(negedge clk);
        check_bit(mflags[64], 1'b1);
        check_bit(exc, 1'b1);
        @(negedge clk);
        check_bit(flags[2], 1'b1);
        @(posedge clk);
        ev_mask[64] <= 1'b1;
        repeat (3) @(negedge clk);
        check_bit(mflags[64], 1'b0);
        clear_all();
        @(posedge clk);
        {ev_in[9], ev_in[11]} <= 2'h3;
        @(posedge clk);
        ev_in <= '0;
        @(negedge clk);
        check_vec(128'(emu), 128'(3'h3));
        @(negedge clk);
        check_vec(128'(emu), 128'(3'h0));
        check_bit(nmi, 1'b0);
        wrap_up();
    end
endmodule

// File: logic/event_combiner.sv
// system event combiner feeding the cpu interrupt, exception and emulation inputs
`timescale 1ns/10ps
// ==========================================================
// Overview of operation
// - twelve prioritized cpu interrupt outputs from events
// - each interrupt takes a software-selected event number
// - also drive exception and emulation requests
// - non-maskable interrupt output is tied inactive
// - event numbers fixed per source
// - dropped interrupt raises event 96
// - four groups of flag, set, clear, mask, masked
module event_combiner
    import event_combiner_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [NUM_EVENTS-1:0] EVENT_IN,
    input wire logic [NUM_EVENTS-1:0] EVENT_SET,
    input wire logic [NUM_EVENTS-1:0] EVENT_CLEAR,
    input wire logic [NUM_EVENTS-1:0] EVENT_MASK,
    input wire logic [NUM_EVENTS-1:0] EXCEPTION_ENABLE,
    input wire logic [NUM_CPU_INT-1:0][EVT_SEL_W-1:0] INT_SEL,
    input wire logic [NUM_CPU_INT-1:0] INT_ACK,
    output logic [NUM_EVENTS-1:0] EVENT_FLAGS,
    output logic [NUM_EVENTS-1:0] MASKED_FLAGS,
    output logic [NUM_CPU_INT-1:0] CPU_INT,
    output logic [NUM_CPU_INT-1:0] CPU_INT_PENDING,
    output logic [HIGHEST_W-1:0] HIGHEST_INT,
    output logic CPU_EXCEPTION,
    output logic [2:0] EMU_INT,
    output logic CPU_NMI
);
    logic [NUM_EVENTS-1:0] event_vec;
    logic [NUM_EVENTS-1:0] set_src;
    logic [NUM_EVENTS-1:0] next_flags;
    logic [NUM_GROUPS-1:0] combined;
    logic [NUM_CPU_INT-1:0] drops;
    logic [HIGHEST_W-1:0] next_highest;

    // ==========================================================
    // event vector: external sources in their fixed slots
    always_comb begin
        // internal slots ignore the pins; reserved slots are forced low
        event_vec = EVENT_IN & ~INTERNAL_MASK & ~RESERVED_MASK;
        event_vec[EVT_COMBINED0 +: NUM_GROUPS] = combined;
        event_vec[EVT_DROPPED] = |drops;
    end

    // or of one 32-bit flag group, shared by the combiner and its checks
    function automatic logic group_any(input logic [NUM_EVENTS-1:0] v, input int g);
        return |v[g*GROUP_W +: GROUP_W];
    endfunction

    // combined events; group 0 skips its own combined bits to avoid self-holding
    always_comb begin
        combined[0] = |MASKED_FLAGS[GROUP_W-1:NUM_GROUPS];
        for (int g = 1; g < NUM_GROUPS; g++) begin
            combined[g] = group_any(MASKED_FLAGS, g);
        end
    end

    // ==========================================================
    // flags: hardware or software set wins over clear
    assign set_src = (event_vec | EVENT_SET) & ~RESERVED_MASK;
    assign next_flags = set_src | (EVENT_FLAGS & ~EVENT_CLEAR);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            EVENT_FLAGS <= FLAGS_RESET;
            MASKED_FLAGS <= FLAGS_RESET;
        end else begin
            EVENT_FLAGS <= next_flags;
            MASKED_FLAGS <= EVENT_FLAGS & ~EVENT_MASK;
        end
    end

    // ==========================================================
    // cpu interrupt channels
    for (genvar i = 0; i < NUM_CPU_INT; i++) begin : g_chan
        irq_channel u_chan (
            .clk(CLK),
            .rst_b(RST_B),
            .event_vec(event_vec),
            .sel(INT_SEL[i]),
            .ack(INT_ACK[i]),
            .irq(CPU_INT[i]),
            .pending(CPU_INT_PENDING[i]),
            .drop(drops[i])
        );
    end

    // lowest index is highest priority
    always_comb begin
        next_highest = HIGHEST_NONE;
        for (int i = NUM_CPU_INT - 1; i >= 0; i--) begin
            if (CPU_INT_PENDING[i]) begin
                next_highest = HIGHEST_W'(i);
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            HIGHEST_INT <= HIGHEST_NONE;
        end else begin
            HIGHEST_INT <= next_highest;
        end
    end

    // ==========================================================
    // exception, emulation and non-maskable requests
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            CPU_EXCEPTION <= 1'b0;
            EMU_INT <= 3'h0;
        end else begin
            CPU_EXCEPTION <= |(EVENT_FLAGS & EXCEPTION_ENABLE);
            EMU_INT <= {event_vec[EVT_EMU_TX], event_vec[EVT_EMU_RX],
                event_vec[EVT_EMU_DMA]};
        end
    end

    // no non-maskable source exists in this device
    assign CPU_NMI = 1'b0;

    // ==========================================================
    // checks
    reserved_flags_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (EVENT_FLAGS & RESERVED_MASK) == '0) else $error("reserved event flag set");

    set_wins_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 ($past(EVENT_SET & EVENT_CLEAR & ~RESERVED_MASK) & ~EVENT_FLAGS) == '0)
        else $error("set lost against clear");

    drop_event_a: assert property (@(posedge CLK) disable iff (!RST_B)
        |drops |=> EVENT_FLAGS[EVT_DROPPED]) else $error("drop did not raise event 96");

    nmi_tied_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !CPU_NMI) else $error("nmi asserted");

    combine_group_a: assert property (@(posedge CLK) disable iff (!RST_B)
        |MASKED_FLAGS[2*GROUP_W +: GROUP_W] |=> EVENT_FLAGS[2])
        else $error("combined event 2 not raised");

    masked_view_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 MASKED_FLAGS == ($past(EVENT_FLAGS) & ~$past(EVENT_MASK)))
        else $error("masked flags wrong");

    highest_valid_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 ((HIGHEST_INT == HIGHEST_NONE) == ($past(CPU_INT_PENDING) == '0)))
        else $error("highest pending index wrong");

    emu_route_a: assert property (@(posedge CLK) disable iff (!RST_B)
        EVENT_IN[EVT_EMU_RX] |=> EMU_INT[1]) else $error("emulation event not routed");

    // ==========================================================
    // checks: flag lifetime and hardware sources
    clear_works_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 ($past(EVENT_CLEAR & ~(EVENT_SET | event_vec)) & EVENT_FLAGS) == '0)
        else $error("cleared flag still set");

    flag_sticky_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 ($past(EVENT_FLAGS & ~EVENT_CLEAR) & ~EVENT_FLAGS) == '0)
        else $error("flag lost without a clear");

    source_sets_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 ($past(EVENT_IN & ~INTERNAL_MASK & ~RESERVED_MASK) & ~EVENT_FLAGS) == '0)
        else $error("peripheral event did not set its flag");

    // the pin at slot 96 must never reach the flag, only a real drop or a software set may
    drop_source_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !(|drops) && !EVENT_SET[EVT_DROPPED] && !EVENT_FLAGS[EVT_DROPPED]
        |=> !EVENT_FLAGS[EVT_DROPPED])
        else $error("event 96 set without a dropped interrupt");

    combine_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
        |MASKED_FLAGS[GROUP_W-1:NUM_GROUPS] |=> EVENT_FLAGS[EVT_COMBINED0])
        else $error("combined event 0 not raised");

    combine_one_a: assert property (@(posedge CLK) disable iff (!RST_B)
        group_any(MASKED_FLAGS, 1) |=> EVENT_FLAGS[EVT_COMBINED0 + 1])
        else $error("combined event 1 not raised");

    combine_three_a: assert property (@(posedge CLK) disable iff (!RST_B)
        group_any(MASKED_FLAGS, 3) |=> EVENT_FLAGS[EVT_COMBINED0 + 3])
        else $error("combined event 3 not raised");

    // unmasked flag -> masked view -> combined flag, two edges in all
    sequence s_group2_raw;
        group_any(EVENT_FLAGS & ~EVENT_MASK, 2);
    endsequence

    sequence s_group2_masked;
        group_any(MASKED_FLAGS, 2);
    endsequence

    property p_group2_chain;
        @(posedge CLK) disable iff (!RST_B) s_group2_raw |=> s_group2_masked ##1 EVENT_FLAGS[2];
    endproperty

    combine_chain_a: assert property (p_group2_chain)
        else $error("group 2 flag did not combine in two cycles");

    // ==========================================================
    // checks: requests toward the core
    exception_level_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 CPU_EXCEPTION == (|$past(EVENT_FLAGS & EXCEPTION_ENABLE)))
        else $error("exception request does not follow enabled flags");

    emu_dma_a: assert property (@(posedge CLK) disable iff (!RST_B)
        EVENT_IN[EVT_EMU_DMA] |=> EMU_INT[0])
        else $error("emulation dma event not routed");

    emu_tx_a: assert property (@(posedge CLK) disable iff (!RST_B)
        EVENT_IN[EVT_EMU_TX] |=> EMU_INT[2])
        else $error("emulation transmit event not routed");

    irq_pending_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (CPU_INT & ~CPU_INT_PENDING) == '0)
        else $error("interrupt delivered without pending state");

    // index must point at a pending channel with none pending below it
    highest_first_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 HIGHEST_INT != HIGHEST_NONE |->
        ((($past(CPU_INT_PENDING) >> HIGHEST_INT) & 12'h001) != '0) &&
        (($past(CPU_INT_PENDING) & ((12'h001 << HIGHEST_INT) - 12'h001)) == '0))
        else $error("highest pending index not the first pending");
endmodule

// File: logic/event_combiner_pkg.sv
// constants shared by the event combiner and its interrupt channels
package event_combiner_pkg;
    localparam int NUM_EVENTS = 128;
    localparam int NUM_CPU_INT = 12;
    localparam int EVT_SEL_W = 7;
    localparam int GROUP_W = 32;
    localparam int NUM_GROUPS = 4;
    localparam int HIGHEST_W = 4;
    // fixed event numbers
    localparam int EVT_COMBINED0 = 0;
    localparam int EVT_TIMER0_LOW = 4;
    localparam int EVT_WATCHDOG = 8;
    localparam int EVT_EMU_DMA = 9;
    localparam int EVT_EMU_RX = 11;
    localparam int EVT_EMU_TX = 12;
    localparam int EVT_INT_DMA0 = 13;
    localparam int EVT_PIN0 = 64;
    localparam int EVT_PIN_BANK0 = 72;
    localparam int EVT_PWM0 = 80;
    localparam int EVT_TWO_WIRE = 83;
    localparam int EVT_SERIAL0 = 84;
    localparam int EVT_DROPPED = 96;
    // reserved event numbers, never able to set a flag
    localparam logic [127:0] RESERVED_MASK =
        128'h000D_FFFC_FFC0_8000_E610_7403_FFFF_8400;
    // events generated inside the combiner: 0-3 and 96
    localparam logic [127:0] INTERNAL_MASK =
        128'h0000_0001_0000_0000_0000_0000_0000_000F;
    localparam logic [127:0] FLAGS_RESET = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
    localparam logic [HIGHEST_W-1:0] HIGHEST_NONE = 4'hF;
endpackage

// File: logic/irq_channel.sv
// one cpu interrupt channel: event select, edge detect, pending and drop detection
`timescale 1ns/10ps
module irq_channel
    import event_combiner_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_EVENTS-1:0] event_vec,
    input wire logic [EVT_SEL_W-1:0] sel,
    input wire logic ack,
    output logic irq,
    output logic pending,
    output logic drop
);
    logic line;
    logic line_q;
    logic edge_seen;

    // ==========================================================
    // event selection
    assign line = event_vec[sel];
    assign edge_seen = line & ~line_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            line_q <= 1'b0;
        end else begin
            line_q <= line;
        end
    end

    // ==========================================================
    // delivery and pending state; a new edge wins over an ack
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending <= 1'b0;
        end else if (edge_seen) begin
            pending <= 1'b1;
        end else if (ack) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
            drop <= 1'b0;
        end else begin
            irq <= edge_seen & ~pending;
            drop <= edge_seen & pending;
        end
    end

    // ==========================================================
    // checks
    sequence s_fresh;
        edge_seen && !pending;
    endsequence

    sequence s_lost;
        edge_seen && pending;
    endsequence

    property p_fire;
        @(posedge clk) disable iff (!rst_b) s_fresh |=> irq && !drop ##1 !irq;
    endproperty

    irq_fire_once_a: assert property (p_fire) else $error("fresh event did not pulse irq");

    irq_drop_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        s_lost |=> drop && !irq) else $error("lost event not reported as dropped");

    ack_clears_a: assert property (@(posedge clk) disable iff (!rst_b)
        ack && !edge_seen |=> !pending) else $error("ack did not clear pending");

    select_route_a: assert property (@(posedge clk) disable iff (!rst_b)
        irq |-> $past(event_vec[sel] && !line_q)) else $error("irq without selected edge");
endmodule
